// File: rtl/usart_regs_consts.svh
// Register offsets, field positions and reset values of the serial transceiver
`ifndef USART_REGS_CONSTS_SVH
`define USART_REGS_CONSTS_SVH
`define OFF_MODE_CTRL 8'h00
`define OFF_LINE_STATUS 8'h04
`define OFF_IRQ_STATUS 8'h08
`define OFF_IRQ_MASK 8'h0C
`define OFF_RX_HOLDING 8'h18
`define OFF_TX_HOLDING 8'h1C
`define OFF_BAUD_GENERATOR 8'h20
`define OFF_RX_SILENCE_LIMIT 8'h24
`define OFF_TX_CHAR_GAP 8'h28
`define OFF_SMARTCARD_CLOCK_RATIO 8'h40
`define OFF_SMARTCARD_ERROR_COUNT 8'h44
`define OFF_INFRARED_FILTER 8'h4C
`define OFF_MANCHESTER_CONFIG 8'h50
`define POS_MARKER 15
`define POS_BAUD_FRACTION 16
`define POS_TX_PREAMBLE_PATTERN 8
`define POS_TX_MANCHESTER_POLARITY 12
`define POS_RX_PREAMBLE_LEN 16
`define POS_RX_PREAMBLE_PATTERN 24
`define POS_RX_MANCHESTER_POLARITY 28
`define POS_DRIFT 30
`define POS_MANCHESTER_EN 2
`define POS_START_TIMEOUT 3
`define RST_SMARTCARD_CLOCK_RATIO 11'h174
`define RST_MANCHESTER_CONFIG 32'h00000000
`define OVS_ASYNC16 11'h010
`define OVS_ASYNC8 11'h008
`define OVS_SYNC 11'h001
`define DATA_BITS_LAST 8'h07
`define ERROR_COUNT_MAX 8'hFF
`define DRIFT_WINDOW 11'h002
`endif

// File: rtl/usart_regs_pkg.sv
// Types shared by the serial transceiver register block
package usart_regs_pkg;
    typedef enum logic [1:0] {MODE_ASYNC16, MODE_ASYNC8, MODE_SYNC, MODE_SMARTCARD} clock_mode_type;
    typedef enum {TX_IDLE, TX_PRE, TX_START, TX_DATA, TX_STOP, TX_GUARD} tx_state_type;
    typedef enum {RX_IDLE, RX_PRE, RX_START, RX_DATA, RX_STOP} rx_state_type;
endpackage

// File: rtl/usart_regs.sv
// Serial transceiver core: holding registers, baud generator, time-outs, Manchester coding
`timescale 1ns/10ps
`include "usart_regs_consts.svh"

// Summary of operation
// - Receive holding shows last received character
// - Receive marker bit: 0 data, 1 command
// - Written character sends after current one
// - Transmit marker selects data or command sync
// - Divisor zero stops clock; mode sets division
// - Fraction adds eighths to divisor; zero off
// - Silence limit times bit period; zero off
// - Idle gap inserts bit periods between characters
// - Smart-card ratio divides serial clock; zero stops
// - Error counter counts, clears on read
// - Transmit preamble length and pattern select
// - Receive preamble detection, same pattern codes
// - Polarity bit inverts Manchester transition mapping
// - Drift bit resynchronises receiver in 16x mode
// - Infrared filter field drives demodulator filter
// - Receiver ready set until holding register read
module usart_regs
    import usart_regs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic [7:0] ir_filter_o,
    output logic irq_o
);
    // Pattern bit expected at a preamble position, shared by both directions
    function automatic logic pre_bit(input logic [1:0] pp, input logic [3:0] idx);
        logic b;
        b = 1'b0;
        case (pp)
            2'h0: b = 1'b1;
            2'h1: b = 1'b0;
            2'h2: b = idx[0];
            default: b = ~idx[0];
        endcase
        return b;
    endfunction

    // Software state
    logic [31:0] mode_ctrl_q, baud_q, man_q, irq_mask_q;
    logic [15:0] rto_q;
    logic [7:0] tg_q, if_q, ner_q, ner_d;
    logic [10:0] ratio_q;
    logic [3:0] irq_st_q, irq_st_d, irq_ev;
    logic [31:0] rd_data_d;
    logic irq_q, txd_q;

    // Bus decode
    wire wr_mode = wr_i && en_i && addr_i == `OFF_MODE_CTRL;
    wire wr_irq_st = wr_i && en_i && addr_i == `OFF_IRQ_STATUS;
    wire wr_thr = wr_i && en_i && addr_i == `OFF_TX_HOLDING;
    wire rd_rhr = rd_i && en_i && addr_i == `OFF_RX_HOLDING;
    wire rd_ner = rd_i && en_i && addr_i == `OFF_SMARTCARD_ERROR_COUNT;
    wire start_to = wr_mode && wr_data_i[`POS_START_TIMEOUT];

    // Configuration fields
    wire clock_mode_type mode = clock_mode_type'(mode_ctrl_q[1:0]);
    wire man_en = mode_ctrl_q[`POS_MANCHESTER_EN];
    wire [15:0] baud_div = baud_q[15:0];
    wire [2:0] baud_frac = baud_q[`POS_BAUD_FRACTION +: 3];
    wire [3:0] tx_preamble_len = man_q[3:0];
    wire [1:0] tx_preamble_pattern = man_q[`POS_TX_PREAMBLE_PATTERN +: 2];
    wire tx_pol = man_q[`POS_TX_MANCHESTER_POLARITY];
    wire [3:0] rx_preamble_len = man_q[`POS_RX_PREAMBLE_LEN +: 4];
    wire [1:0] rx_preamble_pattern = man_q[`POS_RX_PREAMBLE_PATTERN +: 2];
    wire rx_pol = man_q[`POS_RX_MANCHESTER_POLARITY];
    wire drift = man_q[`POS_DRIFT];

    // Oversampling per bit: 16, 8, 1 or the smart-card ratio
    wire [10:0] ovs = (mode == MODE_ASYNC16) ? `OVS_ASYNC16 :
                      (mode == MODE_ASYNC8) ? `OVS_ASYNC8 :
                      (mode == MODE_SYNC) ? `OVS_SYNC : ratio_q;
    wire [10:0] half = ovs >> 1;

    // Baud generator: sample tick every divisor cycles plus fraction carries
    logic [16:0] div_cnt_q;
    logic [2:0] frac_acc_q;
    logic [10:0] samp_cnt_q;
    wire [3:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, baud_frac};
    wire sample_tick = en_i && baud_div != 16'h0000 && div_cnt_q == 17'h00000;
    wire bit_tick = sample_tick && ovs != 11'h000 && samp_cnt_q == ovs - 11'h001;
    wire second_half = samp_cnt_q >= half;

    // Reload adds one cycle whenever the eighths accumulator wraps
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= 17'h00000;
            frac_acc_q <= 3'h0;
            samp_cnt_q <= 11'h000;
        end else if (en_i) begin
            if (baud_div == 16'h0000) begin
                div_cnt_q <= 17'h00000;
            end else if (div_cnt_q == 17'h00000) begin
                div_cnt_q <= {1'b0, baud_div} - 17'h00001 + {16'h0000, frac_sum[3]};
                frac_acc_q <= frac_sum[2:0];
                samp_cnt_q <= bit_tick || samp_cnt_q >= ovs ? 11'h000 : samp_cnt_q + 11'h001;
            end else begin
                div_cnt_q <= div_cnt_q - 17'h00001;
            end
        end
    end

    // Transmitter: holding register feeding the shifter
    tx_state_type tx_state_q;
    logic [7:0] hold_q, tx_shift_q, tx_cnt_q;
    logic hold_cmd_q, hold_valid_q, tx_cmd_q;
    wire tx_load = bit_tick && tx_state_q == TX_IDLE && hold_valid_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state_q <= TX_IDLE;
            hold_q <= 8'h00;
            hold_cmd_q <= 1'b0;
            hold_valid_q <= 1'b0;
            tx_shift_q <= 8'h00;
            tx_cmd_q <= 1'b0;
            tx_cnt_q <= 8'h00;
        end else if (en_i) begin
            if (tx_load) begin
                hold_valid_q <= 1'b0;
            end
            // A write in the load cycle refills the holder, so nothing is dropped
            if (wr_thr) begin
                hold_q <= wr_data_i[7:0];
                hold_cmd_q <= wr_data_i[`POS_MARKER];
                hold_valid_q <= 1'b1;
            end
            if (bit_tick) begin
                case (tx_state_q)
                    TX_IDLE: begin
                        if (hold_valid_q) begin
                            tx_shift_q <= hold_q;
                            tx_cmd_q <= hold_cmd_q;
                            tx_cnt_q <= 8'h00;
                            tx_state_q <= (man_en && tx_preamble_len != 4'h0) ? TX_PRE : TX_START;
                        end
                    end
                    TX_PRE: begin
                        tx_cnt_q <= tx_cnt_q + 8'h01;
                        if (tx_cnt_q[3:0] == tx_preamble_len - 4'h1) begin
                            tx_cnt_q <= 8'h00;
                            tx_state_q <= TX_START;
                        end
                    end
                    TX_START: tx_state_q <= TX_DATA;
                    TX_DATA: begin
                        tx_shift_q <= tx_shift_q >> 1;
                        tx_cnt_q <= tx_cnt_q + 8'h01;
                        if (tx_cnt_q == `DATA_BITS_LAST) begin
                            tx_cnt_q <= 8'h00;
                            tx_state_q <= man_en ? (tg_q != 8'h00 ? TX_GUARD : TX_IDLE) : TX_STOP;
                        end
                    end
                    TX_STOP: tx_state_q <= tg_q != 8'h00 ? TX_GUARD : TX_IDLE;
                    TX_GUARD: begin
                        tx_cnt_q <= tx_cnt_q + 8'h01;
                        if (tx_cnt_q >= tg_q - 8'h01) begin
                            tx_state_q <= TX_IDLE;
                        end
                    end
                    default: tx_state_q <= TX_IDLE;
                endcase
            end
        end
    end

    // Line level of the current bit; sync is a marker bit in Manchester, a low start otherwise
    wire tx_bit = (tx_state_q == TX_PRE) ? pre_bit(tx_preamble_pattern, tx_cnt_q[3:0]) :
                  (tx_state_q == TX_START) ? (man_en & tx_cmd_q) :
                  (tx_state_q == TX_DATA) ? tx_shift_q[0] : 1'b1;
    wire tx_coded = tx_state_q == TX_PRE || tx_state_q == TX_START || tx_state_q == TX_DATA;
    wire tx_half = tx_bit ^ tx_pol ^ second_half;
    wire txd_d = (man_en && tx_coded) ? tx_half : tx_bit;

    // Receiver: NRZ frames or Manchester with preamble and marker bit
    rx_state_type rx_state_q;
    logic [10:0] rx_cnt_q;
    logic [7:0] rx_shift_q, rx_char_q, rx_bits_q;
    logic rx_cmd_sh_q, rx_cmd_q, receiver_ready_flag_q, rxd_prev_q;
    wire rx_edge = rxd_i != rxd_prev_q;
    wire rx_fall = rxd_prev_q && !rxd_i;
    wire [10:0] rx_point = man_en ? (ovs >> 2) : half;
    wire rx_mid = sample_tick && rx_cnt_q == rx_point;
    wire rx_bit = man_en ? (rxd_i ^ rx_pol) : rxd_i;
    wire rx_last = rx_bits_q == `DATA_BITS_LAST;
    wire char_done = rx_mid && ((rx_state_q == RX_DATA && rx_last && man_en) || rx_state_q == RX_STOP);
    wire frame_err = rx_mid && rx_state_q == RX_STOP && !rxd_i;
    // Drift window: an edge near mid-bit is a Manchester transition, recentre on it
    wire drift_fix = man_en && drift && mode == MODE_ASYNC16 && rx_edge && rx_state_q != RX_IDLE &&
                     rx_cnt_q >= half - `DRIFT_WINDOW && rx_cnt_q <= half + `DRIFT_WINDOW;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_q <= RX_IDLE;
            rx_cnt_q <= 11'h000;
            rx_bits_q <= 8'h00;
            rx_shift_q <= 8'h00;
            rx_cmd_sh_q <= 1'b0;
            rxd_prev_q <= 1'b1;
        end else if (en_i) begin
            rxd_prev_q <= rxd_i;
            if (drift_fix) begin
                rx_cnt_q <= half;
            end else if (sample_tick) begin
                rx_cnt_q <= rx_cnt_q >= ovs - 11'h001 ? 11'h000 : rx_cnt_q + 11'h001;
            end
            case (rx_state_q)
                RX_IDLE: begin
                    if (man_en ? rx_edge : rx_fall) begin
                        rx_cnt_q <= 11'h000;
                        rx_bits_q <= 8'h00;
                        rx_state_q <= (man_en && rx_preamble_len != 4'h0) ? RX_PRE : RX_START;
                    end
                end
                RX_PRE: if (rx_mid) begin
                    rx_bits_q <= rx_bits_q + 8'h01;
                    if (rx_bit != pre_bit(rx_preamble_pattern, rx_bits_q[3:0])) begin
                        rx_state_q <= RX_IDLE;
                    end else if (rx_bits_q[3:0] == rx_preamble_len - 4'h1) begin
                        rx_bits_q <= 8'h00;
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: if (rx_mid) begin
                    rx_cmd_sh_q <= man_en & rx_bit;
                    rx_state_q <= (!man_en && rx_bit) ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_mid) begin
                    rx_shift_q <= {rx_bit, rx_shift_q[7:1]};
                    rx_bits_q <= rx_bits_q + 8'h01;
                    if (rx_last) begin
                        rx_state_q <= man_en ? RX_IDLE : RX_STOP;
                    end
                end
                RX_STOP: if (rx_mid) rx_state_q <= RX_IDLE;
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Captured character and ready flag; a completion beats a read in the same cycle
    wire [7:0] rx_word = man_en ? {rx_bit, rx_shift_q[7:1]} : rx_shift_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_char_q <= 8'h00;
            rx_cmd_q <= 1'b0;
            receiver_ready_flag_q <= 1'b0;
        end else if (en_i) begin
            if (char_done) begin
                rx_char_q <= rx_word;
                rx_cmd_q <= rx_cmd_sh_q;
                receiver_ready_flag_q <= 1'b1;
            end else if (rd_rhr) begin
                receiver_ready_flag_q <= 1'b0;
            end
        end
    end

    // Receive time-out in bit periods, armed only by the start command
    logic [15:0] to_cnt_q;
    logic to_run_q, to_flag_q;
    wire to_expire = to_run_q && bit_tick && to_cnt_q == rto_q - 16'h0001;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            to_cnt_q <= 16'h0000;
            to_run_q <= 1'b0;
            to_flag_q <= 1'b0;
        end else if (en_i) begin
            if (start_to) begin
                to_cnt_q <= 16'h0000;
                to_run_q <= rto_q != 16'h0000;
                to_flag_q <= 1'b0;
            end else if (to_expire) begin
                to_run_q <= 1'b0;
                to_flag_q <= 1'b1;
            end else if (to_run_q && bit_tick) begin
                to_cnt_q <= to_cnt_q + 16'h0001;
            end
        end
    end

    // Smart-card error count saturates; an error in the read cycle survives the clear
    wire sc_err = frame_err && mode == MODE_SMARTCARD;
    always_comb begin
        ner_d = rd_ner ? 8'h00 : ner_q;
        if (sc_err && ner_d != `ERROR_COUNT_MAX) begin
            ner_d = ner_d + 8'h01;
        end
    end

    // Sticky events: char received, time-out, framing error, holder emptied
    assign irq_ev = {tx_load, frame_err, to_expire, char_done};
    assign irq_st_d = (irq_st_q & ~(wr_irq_st ? wr_data_i[3:0] : 4'h0)) | irq_ev;

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (addr_i)
            `OFF_MODE_CTRL: rd_data_d = {mode_ctrl_q[31:4], 1'b0, mode_ctrl_q[2:0]};
            `OFF_LINE_STATUS: rd_data_d = {28'h0000000, to_flag_q, tx_state_q != TX_IDLE, !hold_valid_q, receiver_ready_flag_q};
            `OFF_IRQ_STATUS: rd_data_d = {28'h0000000, irq_st_q};
            `OFF_IRQ_MASK: rd_data_d = irq_mask_q;
            `OFF_RX_HOLDING: rd_data_d = {16'h0000, rx_cmd_q, 7'h00, rx_char_q};
            `OFF_BAUD_GENERATOR: rd_data_d = {13'h0000, baud_q[18:0]};
            `OFF_RX_SILENCE_LIMIT: rd_data_d = {16'h0000, rto_q};
            `OFF_TX_CHAR_GAP: rd_data_d = {24'h000000, tg_q};
            `OFF_SMARTCARD_CLOCK_RATIO: rd_data_d = {21'h000000, ratio_q};
            `OFF_SMARTCARD_ERROR_COUNT: rd_data_d = {24'h000000, ner_q};
            `OFF_INFRARED_FILTER: rd_data_d = {24'h000000, if_q};
            `OFF_MANCHESTER_CONFIG: rd_data_d = man_q;
            default: rd_data_d = 32'h00000000;
        endcase
    end

    // Register writes and registered outputs
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_ctrl_q <= 32'h00000000;
            baud_q <= 32'h00000000;
            rto_q <= 16'h0000;
            tg_q <= 8'h00;
            ratio_q <= `RST_SMARTCARD_CLOCK_RATIO;
            man_q <= `RST_MANCHESTER_CONFIG;
            if_q <= 8'h00;
            irq_mask_q <= 32'h00000000;
            irq_st_q <= 4'h0;
            ner_q <= 8'h00;
            rd_data_o <= 32'h00000000;
            irq_q <= 1'b0;
            txd_q <= 1'b1;
            ir_filter_o <= 8'h00;
        end else if (en_i) begin
            if (wr_i) begin
                case (addr_i)
                    `OFF_MODE_CTRL: mode_ctrl_q <= {28'h0000000, 1'b0, wr_data_i[2:0]};
                    `OFF_IRQ_MASK: irq_mask_q <= {28'h0000000, wr_data_i[3:0]};
                    `OFF_BAUD_GENERATOR: baud_q <= {13'h0000, wr_data_i[18:0]};
                    `OFF_RX_SILENCE_LIMIT: rto_q <= wr_data_i[15:0];
                    `OFF_TX_CHAR_GAP: tg_q <= wr_data_i[7:0];
                    `OFF_SMARTCARD_CLOCK_RATIO: ratio_q <= wr_data_i[10:0];
                    `OFF_INFRARED_FILTER: if_q <= wr_data_i[7:0];
                    `OFF_MANCHESTER_CONFIG: man_q <= wr_data_i & 32'h530F_130F;
                    default: ;
                endcase
            end
            irq_st_q <= irq_st_d;
            ner_q <= ner_d;
            rd_data_o <= rd_i ? rd_data_d : 32'h00000000;
            irq_q <= |(irq_st_q & irq_mask_q[3:0]);
            txd_q <= txd_d;
            ir_filter_o <= if_q;
        end
    end

    assign irq_o = irq_q;
    assign txd_o = txd_q;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    rx_ready_set_a: assert property (char_done |=> receiver_ready_flag_q)
        else $error("receiver ready not set after a character");
    rx_char_load_a: assert property (char_done |=> rx_char_q == $past(rx_word))
        else $error("receive holding not loaded with the finished character");
    rx_marker_read_a: assert property (rd_rhr |=> rd_data_o[15] == $past(rx_cmd_q) &&
                                       rd_data_o[7:0] == $past(rx_char_q))
        else $error("receive holding read mismatch");
    tx_ready_clear_a: assert property (wr_thr |=> hold_valid_q)
        else $error("transmitter ready still set after write");
    baud_off_a: assert property (baud_div == 16'h0000 |-> !sample_tick && !bit_tick)
        else $error("baud tick with zero divisor");
    ratio_off_a: assert property (mode == MODE_SMARTCARD && ratio_q == 11'h000 |-> !bit_tick)
        else $error("bit tick with zero smart-card ratio");
    err_clear_a: assert property (rd_ner && !sc_err |=> ner_q == 8'h00)
        else $error("error counter not cleared by read");
    timeout_cause_a: assert property ($rose(to_flag_q) |-> $past(to_run_q) && rto_q != 16'h0000)
        else $error("time-out without start command");
    guard_idle_a: assert property (tx_state_q == TX_GUARD && en_i |=> txd_o)
        else $error("line not idle during gap");
    preamble_off_a: assert property (tx_state_q == TX_PRE |-> tx_preamble_len != 4'h0 && man_en)
        else $error("preamble sent while disabled");
    irq_level_a: assert property (en_i |=> irq_o == |($past(irq_st_q) & $past(irq_mask_q[3:0])))
        else $error("interrupt level mismatch");
endmodule

// File: verif/serial_line_model.sv
// Far-side serial transceiver model: sends and captures NRZ characters
`timescale 1ns/10ps
module serial_line_model #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    // Line idles high between characters
    initial rxd_o = 1'b1;
    // Start 0, data LSB first, stop level chosen so a framing error can be forced
    task automatic send_char(input logic [7:0] ch, input logic stop_bit);
        logic [9:0] frame;
        frame = {stop_bit, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= frame[i];
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask
    // Samples mid-bit after the first low sample; seen stays 0 if the line never goes low
    task automatic capture_char(input int max_wait, output logic [7:0] ch, output logic stop_bit,
                                output logic seen);
        ch = 8'h00;
        stop_bit = 1'b0;
        seen = 1'b0;
        for (int n = 0; n < max_wait && !seen; n++) begin
            @(posedge clk_i);
            if (txd_i === 1'b0) seen = 1'b1;
        end
        if (seen) begin
            repeat (BIT_CYCLES / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk_i);
                ch[i] = txd_i;
            end
            repeat (BIT_CYCLES) @(posedge clk_i);
            stop_bit = txd_i;
        end
    endtask
endmodule

// File: verif/usart_regs_tb.sv
// Self-checking bench for the serial transceiver register block
`timescale 1ns/10ps
`include "usart_regs_consts.svh"
module usart_regs_tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic en_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rd_data_o;
    logic rxd_i;
    logic txd_o;
    logic [7:0] ir_filter_o;
    logic irq_o;
    int error_cnt = 0;
    int compares = 0;
    // 200 MHz system clock
    always #2.5 sys_clk_i = ~sys_clk_i;
    usart_regs u_usart_regs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rxd_i(rxd_i),
        .txd_o(txd_o), .ir_filter_o(ir_filter_o), .irq_o(irq_o));
    // Divisor 1 and 8 ticks per bit give an 8-cycle bit period on the line
    serial_line_model #(.BIT_CYCLES(8)) u_serial_line_model (.clk_i(sys_clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle strobes; the task returns before the next edge so strobes never collide
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken just after that edge
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        reg_rd(a, d);
        check(what, d, exp);
    endtask
    task automatic test_registers();
        logic [7:0] a [7];
        logic [31:0] m [7];
        a = '{`OFF_BAUD_GENERATOR, `OFF_RX_SILENCE_LIMIT, `OFF_TX_CHAR_GAP, `OFF_SMARTCARD_CLOCK_RATIO,
              `OFF_MANCHESTER_CONFIG, `OFF_INFRARED_FILTER, `OFF_SMARTCARD_ERROR_COUNT};
        m = '{32'h0007FFFF, 32'h0000FFFF, 32'h000000FF, 32'h000007FF, 32'h530F130F, 32'h000000FF, 32'h00000000};
        reg_chk(`OFF_SMARTCARD_CLOCK_RATIO, 32'h00000174, "ratio reset");
        reg_chk(`OFF_MANCHESTER_CONFIG, 32'h00000000, "manchester reset");
        reg_chk(8'hFC, 32'h00000000, "unmapped read");
        check("filter reset", {24'h000000, ir_filter_o}, 32'h00000000);
        // All ones exposes each field's width; the error count is read-only
        for (int i = 0; i < 7; i++) begin
            reg_wr(a[i], 32'hFFFFFFFF);
            reg_chk(a[i], m[i], "field width");
        end
        check("filter out", {24'h000000, ir_filter_o}, 32'h000000FF);
        reg_wr(`OFF_MANCHESTER_CONFIG, 32'h00000000);
        reg_wr(`OFF_TX_CHAR_GAP, 32'h00000000);
        reg_wr(`OFF_RX_SILENCE_LIMIT, 32'h00000000);
        reg_wr(`OFF_MODE_CTRL, 32'h00000001);
        // A zero divisor first empties the long count left by the all-ones write
        reg_wr(`OFF_BAUD_GENERATOR, 32'h00000000);
        reg_wr(`OFF_BAUD_GENERATOR, 32'h00000001);
    endtask
    task automatic test_receive();
        logic [31:0] d;
        reg_chk(`OFF_RX_HOLDING, 32'h00000000, "no char yet");
        u_serial_line_model.send_char(8'hA5, 1'b1);
        d = 32'h0;
        for (int n = 0; n < 20 && d[0] !== 1'b1; n++) reg_rd(`OFF_LINE_STATUS, d);
        check("rx ready", {31'h0, d[0]}, 32'h1);
        reg_chk(`OFF_RX_HOLDING, 32'h000000A5, "rx char");
        reg_rd(`OFF_LINE_STATUS, d);
        check("rx ready cleared", {31'h0, d[0]}, 32'h0);
    endtask
    task automatic test_transmit();
        logic [7:0] ch;
        logic stop_bit;
        logic seen;
        logic [31:0] d;
        reg_wr(`OFF_BAUD_GENERATOR, 32'h00000000);
        reg_wr(`OFF_IRQ_STATUS, 32'h0000000F);
        reg_wr(`OFF_TX_HOLDING, 32'h0000003C);
        u_serial_line_model.capture_char(200, ch, stop_bit, seen);
        check("line still with divisor 0", {31'h0, seen}, 32'h0);
        reg_rd(`OFF_LINE_STATUS, d);
        check("tx ready held", {31'h0, d[1]}, 32'h0);
        fork
            reg_wr(`OFF_BAUD_GENERATOR, 32'h00000001);
            u_serial_line_model.capture_char(300, ch, stop_bit, seen);
        join
        check("tx frame", {22'h0, seen, stop_bit, ch}, 32'h0000033C);
        reg_chk(`OFF_IRQ_STATUS, 32'h00000008, "holder moved");
        check("irq masked", {31'h0, irq_o}, 32'h0);
        reg_wr(`OFF_IRQ_MASK, 32'h00000008);
        repeat (2) @(posedge sys_clk_i);
        check("irq raised", {31'h0, irq_o}, 32'h1);
        reg_wr(`OFF_IRQ_STATUS, 32'h00000008);
        repeat (2) @(posedge sys_clk_i);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        // Manchester, data marker: the model samples each bit's second half, which carries the inverse
        reg_wr(`OFF_MODE_CTRL, 32'h00000005);
        fork
            reg_wr(`OFF_TX_HOLDING, 32'h0000003C);
            u_serial_line_model.capture_char(100, ch, stop_bit, seen);
        join
        check("manchester frame", {22'h0, seen, stop_bit, ch}, 32'h000003C3);
    endtask
    // Limit 4 at 8 cycles per bit expires on the fourth bit tick, within 32 cycles of the command
    task automatic test_timeout();
        logic [31:0] d;
        reg_wr(`OFF_RX_SILENCE_LIMIT, 32'h00000004);
        reg_wr(`OFF_MODE_CTRL, 32'h00000009);
        repeat (14) @(posedge sys_clk_i);
        reg_rd(`OFF_LINE_STATUS, d);
        check("timeout early", {31'h0, d[3]}, 32'h0);
        repeat (40) @(posedge sys_clk_i);
        reg_rd(`OFF_LINE_STATUS, d);
        check("timeout flag", {31'h0, d[3]}, 32'h1);
        reg_rd(`OFF_IRQ_STATUS, d);
        check("timeout event", {31'h0, d[1]}, 32'h1);
    endtask
    // Smart-card bit is divisor times ratio: 1 x 8 cycles
    task automatic test_smartcard();
        logic [31:0] d;
        reg_wr(`OFF_SMARTCARD_CLOCK_RATIO, 32'h00000008);
        reg_wr(`OFF_MODE_CTRL, 32'h00000003);
        reg_rd(`OFF_SMARTCARD_ERROR_COUNT, d);
        u_serial_line_model.send_char(8'h5A, 1'b0);
        repeat (16) @(posedge sys_clk_i);
        reg_chk(`OFF_SMARTCARD_ERROR_COUNT, 32'h00000001, "error count");
        reg_chk(`OFF_SMARTCARD_ERROR_COUNT, 32'h00000000, "count cleared");
    endtask
    task automatic conclude();
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        test_registers();
        test_receive();
        test_transmit();
        test_timeout();
        test_smartcard();
        conclude();
    end
    // Whole run needs under a thousand cycles; 20000 means a hang
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule
